// [hdl/rtc_pkg.sv]
// register map, field layouts, BCD limits and helpers for the clock entry block
// assumes a 32-bit APB slave, BCD time and calendar words and a 32.768 kHz slow clock pin
//
// Operation
// - illegal time or calendar write during a granted update is dropped and sets its validity flag.
// - software cannot clear validity flags; a legal write to that group clears it.
// - time alarm writes get the time checking; date alarm writes check date and month only; each sets its own flag.
// - century outside 19..20 is rejected.
// - year with non-BCD digits is rejected.
// - date outside 01..31 is rejected.
// - month outside 01..12, or too short for the date, is rejected.
// - day of week outside 1..7 is rejected.
// - 24h: hour 00..23 with meridiem clear; 12h: hour 01..12.
// - minutes and seconds must be BCD and at most 59.
// - 12h time-of-day entries are stored and read back as 24h values; time alarm words are stored as written.
// - the meridiem bit 22 of the time word marks PM in 12h mode; the hour format select picks the hour range.
// - time request stops time counting; calendar request stops calendar counting.
// - update acknowledge rises within one slow-clock second of a request.
// - calendar update keeps time running; time update halts both.
// - writing zero to a request ends the update only if it was one.
// - time event source: minute, hour, midnight or noon per select field.
// - calendar event source: Monday, first of month or January first, at midnight.
// - hour format select zero is 24h mode, one is 12h mode.
// - acknowledge reads one only while registers may be updated.
// - seconds event flag sets on each second and holds until cleared.

package rtc_pkg;

	localparam logic [7:0] OFF_UPDATE_CONTROL = 8'h00;
	localparam logic [7:0] OFF_HOUR_FORMAT_CONFIG = 8'h04;
	localparam logic [7:0] OFF_TIME_OF_DAY = 8'h08;
	localparam logic [7:0] OFF_CALENDAR_DATE = 8'h0C;
	localparam logic [7:0] OFF_TIME_ALARM = 8'h10;
	localparam logic [7:0] OFF_DATE_ALARM = 8'h14;
	localparam logic [7:0] OFF_STATUS_FLAGS = 8'h18;
	localparam logic [7:0] OFF_STATUS_CLEAR = 8'h1C;
	localparam logic [7:0] OFF_IRQ_ENABLE_SET = 8'h20;
	localparam logic [7:0] OFF_IRQ_ENABLE_CLEAR = 8'h24;
	localparam logic [7:0] OFF_IRQ_MASK_VIEW = 8'h28;
	localparam logic [7:0] OFF_ENTRY_VALIDITY = 8'h2C;

	localparam logic [31:0] RST_ZERO = 32'h00000000;
	localparam logic [31:0] RST_CALENDAR_DATE = 32'h01210720;
	localparam logic [31:0] RST_DATE_ALARM = 32'h01010000;

	localparam logic [31:0] TIME_MASK = 32'h007F7F7F;
	localparam logic [31:0] CAL_MASK = 32'h3FFFFF7F;
	localparam logic [31:0] TALARM_MASK = 32'h00FFFFFF;
	localparam logic [31:0] CALARM_MASK = 32'hBF9F0000;

	localparam int UPD_TIM_BIT = 0;
	localparam int UPD_CAL_BIT = 1;
	localparam int TEV_SEL_LSB = 8;
	localparam int CEV_SEL_LSB = 16;
	localparam int HR_MODE_BIT = 0;
	localparam int MERIDIEM_BIT = 22;

	localparam int ST_W = 5;
	localparam int ST_ACK = 0;
	localparam int ST_ALARM = 1;
	localparam int ST_SEC = 2;
	localparam int ST_TIME_EVENT_FLAG = 3;
	localparam int ST_CALENDAR_EVENT_FLAG = 4;

	localparam int VE_W = 4;
	localparam int VE_TIME = 0;
	localparam int VE_CAL = 1;
	localparam int VE_TALARM = 2;
	localparam int VE_CALARM = 3;

	localparam int unsigned SLOW_CLK_HZ = 32768;
	localparam int unsigned SEC_PERIOD_S = 1;

	localparam logic [7:0] BCD_ZERO = 8'h00;
	localparam logic [7:0] BCD_ONE = 8'h01;
	localparam logic [3:0] BCD_NINE = 4'h9;
	localparam logic [7:0] BCD_TWELVE = 8'h12;
	localparam logic [7:0] BCD_23 = 8'h23;
	localparam logic [7:0] BCD_28 = 8'h28;
	localparam logic [7:0] BCD_29 = 8'h29;
	localparam logic [7:0] BCD_30 = 8'h30;
	localparam logic [7:0] BCD_31 = 8'h31;
	localparam logic [7:0] BCD_59 = 8'h59;
	localparam logic [7:0] BCD_99 = 8'h99;
	localparam logic [7:0] CENT_MIN = 8'h19;
	localparam logic [7:0] CENT_MAX = 8'h20;
	localparam logic [7:0] MONTH_FEB = 8'h02;
	localparam logic [7:0] MONTH_APR = 8'h04;
	localparam logic [7:0] MONTH_JUN = 8'h06;
	localparam logic [7:0] MONTH_SEP = 8'h09;
	localparam logic [7:0] MONTH_NOV = 8'h11;
	localparam logic [2:0] DAY_FIRST = 3'h1;
	localparam logic [2:0] DAY_LAST = 3'h7;
	localparam logic [4:0] DEC_TEN = 5'h0A;
	localparam logic [4:0] DEC_TWELVE = 5'h0C;
	localparam logic [4:0] DEC_TWENTY = 5'h14;

	typedef enum logic [1:0] {TEV_MINUTE = 2'h0, TEV_HOUR = 2'h1, TEV_MIDNIGHT = 2'h2, TEV_NOON = 2'h3} tev_sel_t;
	typedef enum logic [1:0] {CEV_WEEK = 2'h0, CEV_MONTH = 2'h1, CEV_YEAR = 2'h2, CEV_NONE = 2'h3} cev_sel_t;
	typedef enum logic [1:0] {UPD_IDLE = 2'b00, UPD_WAIT = 2'b01, UPD_GRANT = 2'b11} upd_state_t;

	typedef struct packed {
		logic [8:0] pad_hi;
		logic meridiem;
		logic [5:0] hour;
		logic en_min;
		logic [6:0] minute;
		logic en_sec;
		logic [6:0] second;
	} time_word_t;

	typedef struct packed {
		logic [1:0] pad_hi;
		logic [5:0] date;
		logic [2:0] day;
		logic [4:0] month;
		logic [7:0] year;
		logic pad_lo;
		logic [6:0] cent;
	} cal_word_t;

	function automatic logic bcd_valid(input logic [7:0] v);
		return (v[7:4] <= BCD_NINE) && (v[3:0] <= BCD_NINE);
	endfunction

	function automatic logic [7:0] bcd_inc(input logic [7:0] v);
		if (v[3:0] == BCD_NINE) begin
			return {4'(v[7:4] + 4'h1), 4'h0};
		end
		return {v[7:4], 4'(v[3:0] + 4'h1)};
	endfunction

	// every fourth year, except 1900
	function automatic logic is_leap(input logic [7:0] cent, input logic [7:0] year);
		logic div4;
		div4 = year[4] ? (year[3:0] == 4'h2 || year[3:0] == 4'h6)
			: (year[3:0] == 4'h0 || year[3:0] == 4'h4 || year[3:0] == 4'h8);
		return div4 && !(cent == CENT_MIN && year == BCD_ZERO);
	endfunction

	function automatic logic [7:0] month_days(input logic [7:0] month, input logic leap);
		if (month == MONTH_FEB) begin
			return leap ? BCD_29 : BCD_28;
		end
		if (month == MONTH_APR || month == MONTH_JUN || month == MONTH_SEP || month == MONTH_NOV) begin
			return BCD_30;
		end
		return BCD_31;
	endfunction

endpackage

// [hdl/bcd_entry_checker.sv]
// combinational entry check of one written word as time, calendar or date alarm
// assumes the word is the raw bus write data and the hour format bit is current
`timescale 1ns/10ps
`default_nettype none

module bcd_entry_checker (
	input wire logic [31:0] wdata_in,
	input wire logic hour_mode_in,
	output logic time_ok_out,
	output logic cal_ok_out,
	output logic calarm_ok_out,
	output logic [5:0] hour24_out
);

	rtc_pkg::time_word_t tw;
	rtc_pkg::cal_word_t cw;
	logic [7:0] hr8, min8, sec8, cent8, year8, date8, month8;
	logic hour_ok, date_ok, month_ok;
	logic [4:0] hr_bin, hr_b24;

	always_comb begin
		tw = rtc_pkg::time_word_t'(wdata_in);
		cw = rtc_pkg::cal_word_t'(wdata_in);
		hr8 = {2'b00, tw.hour};
		min8 = {1'b0, tw.minute};
		sec8 = {1'b0, tw.second};
		cent8 = {1'b0, cw.cent};
		year8 = cw.year;
		date8 = {2'b00, cw.date};
		month8 = {3'b000, cw.month};
		if (hour_mode_in) begin
			hour_ok = rtc_pkg::bcd_valid(hr8) && hr8 >= rtc_pkg::BCD_ONE && hr8 <= rtc_pkg::BCD_TWELVE;
		end else begin
			hour_ok = rtc_pkg::bcd_valid(hr8) && hr8 <= rtc_pkg::BCD_23 && !wdata_in[rtc_pkg::MERIDIEM_BIT];
		end
		time_ok_out = hour_ok && rtc_pkg::bcd_valid(min8) && min8 <= rtc_pkg::BCD_59
			&& rtc_pkg::bcd_valid(sec8) && sec8 <= rtc_pkg::BCD_59;
		date_ok = rtc_pkg::bcd_valid(date8) && date8 >= rtc_pkg::BCD_ONE && date8 <= rtc_pkg::BCD_31;
		month_ok = rtc_pkg::bcd_valid(month8) && month8 >= rtc_pkg::BCD_ONE && month8 <= rtc_pkg::BCD_TWELVE;
		cal_ok_out = rtc_pkg::bcd_valid(cent8) && cent8 >= rtc_pkg::CENT_MIN && cent8 <= rtc_pkg::CENT_MAX
			&& rtc_pkg::bcd_valid(year8)
			&& date_ok && month_ok
			&& date8 <= rtc_pkg::month_days(month8, rtc_pkg::is_leap(cent8, year8))
			&& cw.day != 3'h0;
		// alarm has no year, so February 29 is allowed
		calarm_ok_out = date_ok && month_ok && date8 <= rtc_pkg::month_days(month8, 1'b1);
		// 12h entry to 24h storage form
		hr_bin = 5'({3'b000, tw.hour[5:4]} * rtc_pkg::DEC_TEN + {1'b0, tw.hour[3:0]});
		if (hr_bin == rtc_pkg::DEC_TWELVE) begin
			hr_b24 = tw.meridiem ? rtc_pkg::DEC_TWELVE : 5'h00;
		end else begin
			hr_b24 = tw.meridiem ? 5'(hr_bin + rtc_pkg::DEC_TWELVE) : hr_bin;
		end
		if (!hour_mode_in) begin
			hour24_out = tw.hour;
		end else if (hr_b24 >= rtc_pkg::DEC_TWENTY) begin
			hour24_out = {2'b10, 4'(hr_b24 - rtc_pkg::DEC_TWENTY)};
		end else if (hr_b24 >= rtc_pkg::DEC_TEN) begin
			hour24_out = {2'b01, 4'(hr_b24 - rtc_pkg::DEC_TEN)};
		end else begin
			hour24_out = {2'b00, hr_b24[3:0]};
		end
	end

endmodule

`default_nettype wire

// [hdl/bcd_clock_entry_check_and_update.sv]
// APB-mapped BCD time/calendar block: entry checking, update handshake, event sources
// assumes an APB master on sys_clk_in and a free-running 32.768 kHz slow clock on a pin
`timescale 1ns/10ps
`default_nettype none

module bcd_clock_entry_check_and_update #(
	parameter int unsigned SLOW_TICKS_PER_SEC = rtc_pkg::SLOW_CLK_HZ * rtc_pkg::SEC_PERIOD_S
) (
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	input wire logic slow_clk_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [7:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out
);

	localparam int PW = $clog2(SLOW_TICKS_PER_SEC + 1);
	localparam logic [PW-1:0] PRE_LAST = PW'(SLOW_TICKS_PER_SEC - 1);

	////////////////////////////////////////////////////////////////////////////
	// slow clock synchroniser and one-second prescaler

	logic slow_s1_reg, slow_s2_reg, slow_s3_reg, slow_lvl_reg, slow_lvl_next;
	logic slow_rise, sec_tick;
	logic [PW-1:0] pre_reg, pre_next;

	always_comb begin
		slow_lvl_next = slow_lvl_reg;
		if (slow_s2_reg == slow_s3_reg) begin
			slow_lvl_next = slow_s3_reg;
		end
		slow_rise = slow_lvl_next && !slow_lvl_reg;
		pre_next = pre_reg;
		sec_tick = 1'b0;
		if (slow_rise) begin
			if (pre_reg == PRE_LAST) begin
				pre_next = '0;
				sec_tick = 1'b1;
			end else begin
				pre_next = PW'(pre_reg + 1'b1);
			end
		end
	end

	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			slow_s1_reg <= 1'b0;
			slow_s2_reg <= 1'b0;
			slow_s3_reg <= 1'b0;
			slow_lvl_reg <= 1'b0;
			pre_reg <= '0;
		end else begin
			slow_s1_reg <= slow_clk_in;
			slow_s2_reg <= slow_s1_reg;
			slow_s3_reg <= slow_s2_reg;
			slow_lvl_reg <= slow_lvl_next;
			pre_reg <= pre_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// entry checker

	logic time_ok, cal_ok, calarm_ok;
	logic [5:0] hour24;
	logic hr_mode_reg, hr_mode_next;

	bcd_entry_checker u_check (
		.wdata_in(pwdata_in),
		.hour_mode_in(hr_mode_reg),
		.time_ok_out(time_ok),
		.cal_ok_out(cal_ok),
		.calarm_ok_out(calarm_ok),
		.hour24_out(hour24)
	);

	////////////////////////////////////////////////////////////////////////////
	// registers, counters, update handshake

	logic req_tim_reg, req_tim_next, req_cal_reg, req_cal_next;
	rtc_pkg::tev_sel_t tev_sel_reg, tev_sel_next;
	rtc_pkg::cev_sel_t cev_sel_reg, cev_sel_next;
	rtc_pkg::time_word_t time_reg, time_next;
	rtc_pkg::cal_word_t cal_reg, cal_next;
	logic [31:0] talarm_reg, talarm_next, calarm_reg, calarm_next;
	logic [rtc_pkg::ST_W-1:0] st_reg, st_next, st_set, st_clr, imr_reg, imr_next;
	logic [rtc_pkg::VE_W-1:0] ve_reg, ve_next;
	rtc_pkg::upd_state_t upd_reg, upd_next;
	logic [31:0] prdata_reg, prdata_next;
	logic err_reg, err_next;
	logic setup, wr, any_req, min_carry, hr_carry, day_roll, may_write;
	logic [7:0] sec8, min8, hr8, date8, month8, year8, cent8;
	rtc_pkg::time_word_t wtime;

	always_comb begin
		req_tim_next = req_tim_reg;
		req_cal_next = req_cal_reg;
		tev_sel_next = tev_sel_reg;
		cev_sel_next = cev_sel_reg;
		hr_mode_next = hr_mode_reg;
		time_next = time_reg;
		cal_next = cal_reg;
		talarm_next = talarm_reg;
		calarm_next = calarm_reg;
		imr_next = imr_reg;
		ve_next = ve_reg;
		upd_next = upd_reg;
		st_set = '0;
		st_clr = '0;
		min_carry = 1'b0;
		hr_carry = 1'b0;
		day_roll = 1'b0;
		sec8 = {1'b0, time_reg.second};
		min8 = {1'b0, time_reg.minute};
		hr8 = {2'b00, time_reg.hour};
		date8 = {2'b00, cal_reg.date};
		month8 = {3'b000, cal_reg.month};
		year8 = cal_reg.year;
		cent8 = {1'b0, cal_reg.cent};
		any_req = req_tim_reg || req_cal_reg;
		setup = psel_in && !penable_in;
		wr = psel_in && penable_in && pwrite_in;
		wtime = rtc_pkg::time_word_t'(pwdata_in & rtc_pkg::TIME_MASK);
		wtime.hour = hour24;
		wtime.meridiem = 1'b0;

		// time counting stops under a time request
		if (sec_tick) begin
			st_set[rtc_pkg::ST_SEC] = 1'b1;
			if (!req_tim_reg) begin
				if (sec8 != rtc_pkg::BCD_59) begin
					time_next.second = 7'(rtc_pkg::bcd_inc(sec8));
				end else begin
					time_next.second = '0;
					min_carry = 1'b1;
					if (min8 != rtc_pkg::BCD_59) begin
						time_next.minute = 7'(rtc_pkg::bcd_inc(min8));
					end else begin
						time_next.minute = '0;
						hr_carry = 1'b1;
						if (hr8 != rtc_pkg::BCD_23) begin
							time_next.hour = 6'(rtc_pkg::bcd_inc(hr8));
						end else begin
							time_next.hour = '0;
							day_roll = 1'b1;
						end
					end
				end
			end
		end
		unique case (tev_sel_reg)
			rtc_pkg::TEV_MINUTE: st_set[rtc_pkg::ST_TIME_EVENT_FLAG] = min_carry;
			rtc_pkg::TEV_HOUR: st_set[rtc_pkg::ST_TIME_EVENT_FLAG] = hr_carry;
			rtc_pkg::TEV_MIDNIGHT: st_set[rtc_pkg::ST_TIME_EVENT_FLAG] = day_roll;
			rtc_pkg::TEV_NOON: st_set[rtc_pkg::ST_TIME_EVENT_FLAG] = hr_carry
				&& {2'b00, time_next.hour} == rtc_pkg::BCD_TWELVE;
		endcase

		// calendar stops under either request; a day rolled while stopped is lost
		if (day_roll && !req_cal_reg) begin
			cal_next.day = (cal_reg.day == rtc_pkg::DAY_LAST) ? rtc_pkg::DAY_FIRST : 3'(cal_reg.day + 3'h1);
			if (date8 != rtc_pkg::month_days(month8, rtc_pkg::is_leap(cent8, year8))) begin
				cal_next.date = 6'(rtc_pkg::bcd_inc(date8));
			end else begin
				cal_next.date = 6'(rtc_pkg::BCD_ONE);
				if (month8 != rtc_pkg::BCD_TWELVE) begin
					cal_next.month = 5'(rtc_pkg::bcd_inc(month8));
				end else begin
					cal_next.month = 5'(rtc_pkg::BCD_ONE);
					if (year8 != rtc_pkg::BCD_99) begin
						cal_next.year = rtc_pkg::bcd_inc(year8);
					end else begin
						cal_next.year = rtc_pkg::BCD_ZERO;
						cal_next.cent = 7'(rtc_pkg::bcd_inc(cent8));
					end
				end
			end
			unique case (cev_sel_reg)
				rtc_pkg::CEV_WEEK: st_set[rtc_pkg::ST_CALENDAR_EVENT_FLAG] = cal_next.day == rtc_pkg::DAY_FIRST;
				rtc_pkg::CEV_MONTH: st_set[rtc_pkg::ST_CALENDAR_EVENT_FLAG] = cal_next.date == 6'(rtc_pkg::BCD_ONE);
				rtc_pkg::CEV_YEAR: st_set[rtc_pkg::ST_CALENDAR_EVENT_FLAG] = cal_next.date == 6'(rtc_pkg::BCD_ONE)
					&& cal_next.month == 5'(rtc_pkg::BCD_ONE);
				rtc_pkg::CEV_NONE: st_set[rtc_pkg::ST_CALENDAR_EVENT_FLAG] = 1'b0;
			endcase
		end

		// update handshake: grant on the next second tick after a request
		unique case (upd_reg)
			rtc_pkg::UPD_IDLE: begin
				if (any_req) begin
					upd_next = rtc_pkg::UPD_WAIT;
				end
			end
			rtc_pkg::UPD_WAIT: begin
				if (!any_req) begin
					upd_next = rtc_pkg::UPD_IDLE;
				end else if (sec_tick) begin
					upd_next = rtc_pkg::UPD_GRANT;
					st_set[rtc_pkg::ST_ACK] = 1'b1;
				end
			end
			rtc_pkg::UPD_GRANT: begin
				if (!any_req) begin
					upd_next = rtc_pkg::UPD_IDLE;
					st_clr[rtc_pkg::ST_ACK] = 1'b1;
				end
			end
			default: upd_next = rtc_pkg::UPD_IDLE;
		endcase
		may_write = upd_reg == rtc_pkg::UPD_GRANT;

		// software writes, taken at the access edge
		if (wr) begin
			unique case (paddr_in)
				rtc_pkg::OFF_UPDATE_CONTROL: begin
					req_tim_next = pwdata_in[rtc_pkg::UPD_TIM_BIT];
					req_cal_next = pwdata_in[rtc_pkg::UPD_CAL_BIT];
					tev_sel_next = rtc_pkg::tev_sel_t'(pwdata_in[rtc_pkg::TEV_SEL_LSB +: 2]);
					cev_sel_next = rtc_pkg::cev_sel_t'(pwdata_in[rtc_pkg::CEV_SEL_LSB +: 2]);
				end
				rtc_pkg::OFF_HOUR_FORMAT_CONFIG: hr_mode_next = pwdata_in[rtc_pkg::HR_MODE_BIT];
				rtc_pkg::OFF_TIME_OF_DAY: begin
					if (may_write && req_tim_reg) begin
						if (time_ok) begin
							time_next = wtime;
							ve_next[rtc_pkg::VE_TIME] = 1'b0;
						end else begin
							ve_next[rtc_pkg::VE_TIME] = 1'b1;
						end
					end
				end
				rtc_pkg::OFF_CALENDAR_DATE: begin
					if (may_write && req_cal_reg) begin
						if (cal_ok) begin
							cal_next = rtc_pkg::cal_word_t'(pwdata_in & rtc_pkg::CAL_MASK);
							ve_next[rtc_pkg::VE_CAL] = 1'b0;
						end else begin
							ve_next[rtc_pkg::VE_CAL] = 1'b1;
						end
					end
				end
				rtc_pkg::OFF_TIME_ALARM: begin
					if (time_ok) begin
						talarm_next = pwdata_in & rtc_pkg::TALARM_MASK;
						ve_next[rtc_pkg::VE_TALARM] = 1'b0;
					end else begin
						ve_next[rtc_pkg::VE_TALARM] = 1'b1;
					end
				end
				rtc_pkg::OFF_DATE_ALARM: begin
					if (calarm_ok) begin
						calarm_next = pwdata_in & rtc_pkg::CALARM_MASK;
						ve_next[rtc_pkg::VE_CALARM] = 1'b0;
					end else begin
						ve_next[rtc_pkg::VE_CALARM] = 1'b1;
					end
				end
				rtc_pkg::OFF_STATUS_CLEAR: st_clr = st_clr | pwdata_in[rtc_pkg::ST_W-1:0];
				rtc_pkg::OFF_IRQ_ENABLE_SET: imr_next = imr_reg | pwdata_in[rtc_pkg::ST_W-1:0];
				rtc_pkg::OFF_IRQ_ENABLE_CLEAR: imr_next = imr_reg & ~pwdata_in[rtc_pkg::ST_W-1:0];
				default: imr_next = imr_reg;
			endcase
		end
		// a hardware set in the clearing cycle wins
		st_next = (st_reg & ~st_clr) | st_set;

		// read data and error are taken in the setup cycle
		prdata_next = prdata_reg;
		err_next = err_reg;
		if (setup) begin
			err_next = 1'b0;
			unique case (paddr_in)
				rtc_pkg::OFF_UPDATE_CONTROL: prdata_next = {14'h0000, cev_sel_reg, 6'h00, tev_sel_reg,
					6'h00, req_cal_reg, req_tim_reg};
				rtc_pkg::OFF_HOUR_FORMAT_CONFIG: prdata_next = {31'h00000000, hr_mode_reg};
				rtc_pkg::OFF_TIME_OF_DAY: prdata_next = time_reg;
				rtc_pkg::OFF_CALENDAR_DATE: prdata_next = cal_reg;
				rtc_pkg::OFF_TIME_ALARM: prdata_next = talarm_reg;
				rtc_pkg::OFF_DATE_ALARM: prdata_next = calarm_reg;
				rtc_pkg::OFF_STATUS_FLAGS: prdata_next = {27'h0000000, st_reg};
				rtc_pkg::OFF_IRQ_MASK_VIEW: prdata_next = {27'h0000000, imr_reg};
				rtc_pkg::OFF_ENTRY_VALIDITY: prdata_next = {28'h0000000, ve_reg};
				rtc_pkg::OFF_STATUS_CLEAR, rtc_pkg::OFF_IRQ_ENABLE_SET,
				rtc_pkg::OFF_IRQ_ENABLE_CLEAR: prdata_next = rtc_pkg::RST_ZERO;
				default: begin
					prdata_next = rtc_pkg::RST_ZERO;
					err_next = 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			req_tim_reg <= 1'b0;
			req_cal_reg <= 1'b0;
			tev_sel_reg <= rtc_pkg::TEV_MINUTE;
			cev_sel_reg <= rtc_pkg::CEV_WEEK;
			hr_mode_reg <= 1'b0;
			time_reg <= rtc_pkg::time_word_t'(rtc_pkg::RST_ZERO);
			cal_reg <= rtc_pkg::cal_word_t'(rtc_pkg::RST_CALENDAR_DATE);
			talarm_reg <= rtc_pkg::RST_ZERO;
			calarm_reg <= rtc_pkg::RST_DATE_ALARM;
			st_reg <= '0;
			imr_reg <= '0;
			ve_reg <= '0;
			upd_reg <= rtc_pkg::UPD_IDLE;
			prdata_reg <= rtc_pkg::RST_ZERO;
			err_reg <= 1'b0;
		end else begin
			req_tim_reg <= req_tim_next;
			req_cal_reg <= req_cal_next;
			tev_sel_reg <= tev_sel_next;
			cev_sel_reg <= cev_sel_next;
			hr_mode_reg <= hr_mode_next;
			time_reg <= time_next;
			cal_reg <= cal_next;
			talarm_reg <= talarm_next;
			calarm_reg <= calarm_next;
			st_reg <= st_next;
			imr_reg <= imr_next;
			ve_reg <= ve_next;
			upd_reg <= upd_next;
			prdata_reg <= prdata_next;
			err_reg <= err_next;
		end
	end

	assign prdata_out = prdata_reg;
	assign pready_out = psel_in && penable_in;
	assign pslverr_out = psel_in && penable_in && err_reg;

endmodule

`default_nettype wire

// [dv/rtc_entry_sva.sv]
// checker for the register bus side of the clock entry block
// assumes it is bound to the top module and sees only its ports
`timescale 1ns/10ps
`default_nettype none

module rtc_entry_sva (
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [7:0] paddr_in,
	input wire logic [31:0] prdata_out,
	input wire logic pready_out,
	input wire logic pslverr_out
);
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!rst_n_in);
	logic acc;
	logic rd;
	logic mapped;
	assign acc = psel_in && penable_in;
	assign rd = acc && !pwrite_in;
	assign mapped = (paddr_in <= 8'h2C) && (paddr_in[1:0] == 2'h0);
	a_ready_access: assert property (acc |-> pready_out) else $error("no ready in access phase");
	a_ready_idle: assert property (!psel_in |-> !pready_out) else $error("ready while not selected");
	a_err_unmapped: assert property (acc && !mapped |-> pslverr_out && (pwrite_in || prdata_out == 32'h0))
		else $error("unmapped access not refused");
	a_err_mapped: assert property (acc && mapped |-> !pslverr_out) else $error("error on mapped address");
	a_err_phase: assert property (pslverr_out |-> acc) else $error("error outside access phase");
	a_rdata_hold: assert property (!psel_in |=> $stable(prdata_out)) else $error("read data moved while idle");
	a_time_reads_24h: assert property (rd && paddr_in == 8'h08 |-> !prdata_out[22] && prdata_out[21:16] <= 6'h23)
		else $error("time read not in 24h form");
	a_status_width: assert property (rd && paddr_in == 8'h18 |-> prdata_out[31:5] == 27'h0)
		else $error("status upper bits set");
	a_validity_width: assert property (rd && paddr_in == 8'h2C |-> prdata_out[31:4] == 28'h0)
		else $error("validity upper bits set");
	a_wo_reads_zero: assert property (rd && (paddr_in inside {8'h1C, 8'h20, 8'h24}) |-> prdata_out == 32'h0)
		else $error("write-only register read nonzero");
endmodule

bind bcd_clock_entry_check_and_update rtc_entry_sva u_sva (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
	.psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
	.prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out));
`default_nettype wire

// [dv/bcd_clock_entry_check_and_update_test.sv]
// self-checking bench: register bus tasks and entry check sequences
// assumes the slow clock is made here, four slow rising edges to a second
`timescale 1ns/10ps
`default_nettype none

module bcd_clock_entry_check_and_update_test;
	logic clk = 1'b0, rst_n = 1'b0, slow = 1'b0, slow_run = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, d;
	logic pready, pslverr, e;
	int errors = 0, cmp_count = 0, cyc = 0, n;
	logic [31:0] rst_tab [12] = '{32'h0, 32'h0, 32'h0, 32'h01210720, 32'h0, 32'h01010000,
		32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};

	bcd_clock_entry_check_and_update #(.SLOW_TICKS_PER_SEC(4)) DUT (.sys_clk_in(clk), .rst_n_in(rst_n),
		.slow_clk_in(slow), .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
		.pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr));

	always #20 clk = ~clk;
	always #320 if (slow_run) slow = ~slow;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			errors++;
			give_verdict();
		end
	end

	task automatic give_verdict();
		if (errors == 0 && cmp_count > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			errors++;
			$display("BAD %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		d = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] wd);
		xfer(1'b1, a, wd);
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 32'h0);
		check(d, exp);
	endtask
	// write one entry, then look at its validity bit and the stored word
	task automatic entry(input logic [7:0] a, input logic [31:0] wd, input int vb, input logic bad,
		input logic [31:0] keep);
		wr(a, wd);
		xfer(1'b0, 8'h2C, 32'h0);
		check({31'h0, d[vb]}, {31'h0, bad});
		rd_chk(a, keep);
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 12; i++) rd_chk(8'(i * 4), rst_tab[i]);
		xfer(1'b0, 8'h30, 32'h0);
		check({31'h0, e}, 32'h1);
		check(d, 32'h0);
		xfer(1'b1, 8'h02, 32'hFFFFFFFF);
		check({31'h0, e}, 32'h1);
		slow_run <= 1'b1;
		wr(8'h08, 32'h00123456);
		rd_chk(8'h08, 32'h0);
		wr(8'h00, 32'h00000003);
		n = 0;
		d = 32'h0;
		while (d[0] !== 1'b1 && n < 40) begin
			xfer(1'b0, 8'h18, 32'h0);
			n++;
		end
		check({31'h0, d[0]}, 32'h1);
		wr(8'h1C, 32'h00000001);
		xfer(1'b0, 8'h18, 32'h0);
		check({31'h0, d[0]}, 32'h0);
		check({31'h0, d[2]}, 32'h1);
		entry(8'h08, 32'h00240000, 0, 1'b1, 32'h0);
		wr(8'h2C, 32'h0);
		rd_chk(8'h2C, 32'h1);
		entry(8'h08, 32'h00400100, 0, 1'b1, 32'h0);
		entry(8'h08, 32'h00005A00, 0, 1'b1, 32'h0);
		entry(8'h08, 32'h00000060, 0, 1'b1, 32'h0);
		entry(8'h08, 32'h00235959, 0, 1'b0, 32'h00235959);
		wr(8'h04, 32'h1);
		rd_chk(8'h04, 32'h1);
		entry(8'h08, 32'h00130000, 0, 1'b1, 32'h00235959);
		entry(8'h08, 32'h00000000, 0, 1'b1, 32'h00235959);
		entry(8'h08, 32'h00450000, 0, 1'b0, 32'h00170000);
		entry(8'h08, 32'h00120000, 0, 1'b0, 32'h00000000);
		wr(8'h04, 32'h0);
		entry(8'h0C, 32'h01210721, 1, 1'b1, 32'h01210720);
		entry(8'h0C, 32'h0121A020, 1, 1'b1, 32'h01210720);
		entry(8'h0C, 32'h32210720, 1, 1'b1, 32'h01210720);
		entry(8'h0C, 32'h01330720, 1, 1'b1, 32'h01210720);
		entry(8'h0C, 32'h30822420, 1, 1'b1, 32'h01210720);
		entry(8'h0C, 32'h29822320, 1, 1'b1, 32'h01210720);
		entry(8'h0C, 32'h01010720, 1, 1'b1, 32'h01210720);
		entry(8'h0C, 32'h29822420, 1, 1'b0, 32'h29822420);
		entry(8'h10, 32'h00006000, 2, 1'b1, 32'h0);
		entry(8'h10, 32'h00801530, 2, 1'b0, 32'h00801530);
		entry(8'h14, 32'h00130000, 3, 1'b1, 32'h01010000);
		entry(8'h14, 32'h82820000, 3, 1'b0, 32'h82820000);
		for (int s = 0; s < 4; s++) begin
			wr(8'h00, 32'h00000003 | (32'(s) << 8) | (32'(s) << 16));
			rd_chk(8'h00, 32'h00000003 | (32'(s) << 8) | (32'(s) << 16));
		end
		// midnight event and month event, then release and let one second roll the clock
		wr(8'h00, 32'h00010203);
		entry(8'h08, 32'h00235959, 0, 1'b0, 32'h00235959);
		wr(8'h1C, 32'h0000001C);
		wr(8'h00, 32'h00010200);
		rd_chk(8'h00, 32'h00010200);
		xfer(1'b0, 8'h18, 32'h0);
		check({31'h0, d[0]}, 32'h0);
		wr(8'h08, 32'h00010000);
		n = 0;
		d = 32'h0;
		while (d[3] !== 1'b1 && n < 40) begin
			xfer(1'b0, 8'h18, 32'h0);
			n++;
		end
		check({31'h0, d[3]}, 32'h1);
		check({31'h0, d[4]}, 32'h1);
		rd_chk(8'h0C, 32'h01A32420);
		xfer(1'b0, 8'h08, 32'h0);
		check({26'h0, d[21:16]}, 32'h0);
		give_verdict();
	end
endmodule
`default_nettype wire
